// File: hdl/crso_pkg.sv
// Package: constants for the auxiliary CMOS reference clock output selector
`default_nettype none
package crso_pkg;
	// Wishbone register map (byte addresses)
	localparam logic [3:0] ADDR_CTRL   = 4'h0;  // Control register
	localparam logic [3:0] ADDR_STATUS = 4'h4;  // Status register

	// Control register field positions
	localparam int CTRL_OVERRANGE_OUTPUT_ENABLE_BIT    = 0;      // Strap override enable
	localparam int CTRL_ORNG_EN_BIT   = 1;      // Over-range output enable
	localparam int CTRL_FIRST_MODE_LO = 4;      // First output mode field, low bit
	localparam int CTRL_SECOND_MODE_LO = 8;     // Second output mode field, low bit

	// Status register field positions
	localparam int STAT_FIRST_FN_LO  = 0;       // First output function code
	localparam int STAT_SECOND_FN_LO = 8;       // Second output function code
	localparam int STAT_STRAP_LO     = 16;      // Strap pin levels
	localparam int STAT_PD_BIT       = 20;      // Power-down pin level
	localparam int STAT_REFSEL_BIT   = 21;      // Reference select pin level

	// Reset value of the control register
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Reference mode / strap codes
	localparam logic [1:0] MODE_OFF  = 2'h0;    // Disabled or over-range
	localparam logic [1:0] MODE_REF  = 2'h1;    // Undivided reference
	localparam logic [1:0] MODE_DIV2 = 2'h2;    // Reference / 2
	localparam logic [1:0] MODE_DIV4 = 2'h3;    // Reference / 4

	// Over-range exists only on the four-channel variant of the part
	localparam logic QUAD_PART = 1'h1;

	// Output function, one-hot
	typedef enum logic [4:0] {
		FN_OFF  = 5'h01,
		FN_ORNG = 5'h02,
		FN_REF  = 5'h04,
		FN_DIV2 = 5'h08,
		FN_DIV4 = 5'h10
	} crso_fn_t;
endpackage
`default_nettype wire

// File: hdl/crso_top.sv
// Module: auxiliary CMOS reference clock output selector with Wishbone registers
//
// Contract
// - Strap-selected clocks present from power-up, power-down low
// - Power-down high disables both auxiliary outputs
// - Register mode fields override strap pins
// - Straps enable both, divide only first output
// - Divided reference beats over-range on same pin
// - Second clock needs first mode above zero
// - First output: strap or register code decode
// - Second output: strap gives reference, register divides
// - Reference select pin picks differential or single-ended
//
// Added by the designer: the Wishbone slave port and the address map.
`default_nettype none
module crso_top (
	input  wire logic        clk_i,                     // 200 MHz system clock
	input  wire logic        rst_i,                     // Synchronous reset, active high
	input  wire logic        wb_cyc_i,                  // Wishbone cycle
	input  wire logic        wb_stb_i,                  // Wishbone strobe
	input  wire logic        wb_we_i,                   // Wishbone write enable
	input  wire logic [3:0]  wb_adr_i,                  // Wishbone byte address
	input  wire logic [3:0]  wb_sel_i,                  // Wishbone byte selects
	input  wire logic [31:0] wb_dat_i,                  // Wishbone write data
	output logic      [31:0] wb_dat_o,                  // Wishbone read data
	output logic             wb_ack_o,                  // Wishbone acknowledge
	input  wire logic [1:0]  clock_strap_pins_i,        // Strap pins
	input  wire logic        power_down_pin_i,          // Global power-down
	input  wire logic        ref_input_select_pin_i,    // 0 differential, 1 single-ended
	input  wire logic        diff_clock_input_i,        // Differential reference, as level
	input  wire logic        single_ended_clock_input_i, // Single-ended reference
	input  wire logic        overrange_first_i,         // Over-range flag, first channel
	input  wire logic        overrange_second_i,        // Over-range flag, second channel
	output logic             aux_out_first_o,           // First auxiliary CMOS output
	output logic             aux_out_second_o           // Second auxiliary CMOS output
);
	// Register state
	logic [31:0] ctrl_q, ctrl_d;                        // Control register
	logic [31:0] rdat_q, rdat_d;                        // Read data
	logic        ack_q,  ack_d;                         // Acknowledge
	// Clock path state
	logic        ref_q, ref_d;                          // Selected reference, sampled
	logic [1:0]  cnt_q, cnt_d;                          // Reference rising edge counter
	crso_pkg::crso_fn_t fn1_q, fn1_d;                   // First output function
	crso_pkg::crso_fn_t fn2_q, fn2_d;                   // Second output function
	logic        out1_q, out1_d;                        // First output flop
	logic        out2_q, out2_d;                        // Second output flop

	// Field views of the control register
	logic        overrange_output_enable;
	logic        orng_en;
	logic [1:0]  mode1;
	logic [1:0]  mode2;
	logic [1:0]  code1;
	logic [1:0]  code2;
	logic        req;
	assign overrange_output_enable  = ctrl_q[crso_pkg::CTRL_OVERRANGE_OUTPUT_ENABLE_BIT];
	assign orng_en = ctrl_q[crso_pkg::CTRL_ORNG_EN_BIT];
	assign mode1   = ctrl_q[crso_pkg::CTRL_FIRST_MODE_LO +: 2];
	assign mode2   = ctrl_q[crso_pkg::CTRL_SECOND_MODE_LO +: 2];
	assign req     = wb_cyc_i & wb_stb_i & ~ack_q;

	// Map a mode code to a function; idle code falls to over-range or off
	function automatic crso_pkg::crso_fn_t decode(input logic [1:0] code, input logic orng);
		crso_pkg::crso_fn_t f;
		unique case (code)
			crso_pkg::MODE_REF:  f = crso_pkg::FN_REF;
			crso_pkg::MODE_DIV2: f = crso_pkg::FN_DIV2;
			crso_pkg::MODE_DIV4: f = crso_pkg::FN_DIV4;
			default:             f = (orng && crso_pkg::QUAD_PART) ? crso_pkg::FN_ORNG
			                                                      : crso_pkg::FN_OFF;
		endcase
		return f;
	endfunction

	// Wishbone slave: one-cycle ack, unmapped reads zero and writes dropped
	always_comb begin
		ctrl_d = ctrl_q;
		rdat_d = rdat_q;
		ack_d  = req;
		if (req) begin
			rdat_d = 32'h0000_0000;
			unique case (wb_adr_i)
				crso_pkg::ADDR_CTRL: begin
					rdat_d = ctrl_q;
					if (wb_we_i) begin
						for (int b = 0; b < 4; b++) begin
							if (wb_sel_i[b]) begin
								ctrl_d[8*b +: 8] = wb_dat_i[8*b +: 8];
							end
						end
					end
				end
				crso_pkg::ADDR_STATUS: begin
					// Live view of the decoded functions and pins
					rdat_d[crso_pkg::STAT_FIRST_FN_LO +: 5]  = fn1_q;
					rdat_d[crso_pkg::STAT_SECOND_FN_LO +: 5] = fn2_q;
					rdat_d[crso_pkg::STAT_STRAP_LO +: 2]     = clock_strap_pins_i;
					rdat_d[crso_pkg::STAT_PD_BIT]            = power_down_pin_i;
					rdat_d[crso_pkg::STAT_REFSEL_BIT]        = ref_input_select_pin_i;
				end
				default: begin
					// Unmapped: ack anyway so the bus never hangs
					rdat_d = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= crso_pkg::CTRL_RESET;
			rdat_q <= 32'h0000_0000;
			ack_q  <= 1'h0;
		end else begin
			ctrl_q <= ctrl_d;
			rdat_q <= rdat_d;
			ack_q  <= ack_d;
		end
	end

	assign wb_dat_o = rdat_q;
	assign wb_ack_o = ack_q;

	// Function decode for both outputs
	always_comb begin
		// Straps steer until software sets the override
		code1 = overrange_output_enable ? mode1 : clock_strap_pins_i;
		// Straps only enable the second output, never divide it
		if (overrange_output_enable) begin
			code2 = mode2;
		end else begin
			code2 = (clock_strap_pins_i != crso_pkg::MODE_OFF) ? crso_pkg::MODE_REF
			                                                    : crso_pkg::MODE_OFF;
		end
		// Second clock only rides along a first clock mode above zero
		if (code1 == crso_pkg::MODE_OFF) begin
			code2 = crso_pkg::MODE_OFF;
		end
		// Any clock code wins before over-range is considered
		fn1_d = decode(code1, orng_en);
		fn2_d = decode(code2, orng_en);
	end

	// Reference selection and divider
	always_comb begin
		ref_d = ref_input_select_pin_i ? single_ended_clock_input_i
		                               : diff_clock_input_i;
		cnt_d = cnt_q;
		// Count rising edges: bit 0 is ref/2, bit 1 is ref/4
		if (ref_d && !ref_q) begin
			cnt_d = cnt_q + 2'h1;
		end
	end

	// Output muxing; power-down overrides everything
	always_comb begin
		unique case (fn1_q)
			crso_pkg::FN_REF:  out1_d = ref_q;
			crso_pkg::FN_DIV2: out1_d = cnt_q[0];
			crso_pkg::FN_DIV4: out1_d = cnt_q[1];
			crso_pkg::FN_ORNG: out1_d = overrange_first_i;
			default:           out1_d = 1'h0;
		endcase
		unique case (fn2_q)
			crso_pkg::FN_REF:  out2_d = ref_q;
			crso_pkg::FN_DIV2: out2_d = cnt_q[0];
			crso_pkg::FN_DIV4: out2_d = cnt_q[1];
			crso_pkg::FN_ORNG: out2_d = overrange_second_i;
			default:           out2_d = 1'h0;
		endcase
		if (power_down_pin_i) begin
			out1_d = 1'h0;
			out2_d = 1'h0;
		end
	end

	// Clock path registers; outputs leave straight from flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_q  <= 1'h0;
			cnt_q  <= 2'h0;
			fn1_q  <= crso_pkg::FN_OFF;
			fn2_q  <= crso_pkg::FN_OFF;
			out1_q <= 1'h0;
			out2_q <= 1'h0;
		end else begin
			ref_q  <= ref_d;
			cnt_q  <= cnt_d;
			fn1_q  <= fn1_d;
			fn2_q  <= fn2_d;
			out1_q <= out1_d;
			out2_q <= out2_d;
		end
	end

	assign aux_out_first_o  = out1_q;
	assign aux_out_second_o = out2_q;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	AST_PD_OFF: assert property (power_down_pin_i |=> !aux_out_first_o && !aux_out_second_o)
		else $error("outputs not off in power-down");
	AST_STRAP_REF: assert property (!overrange_output_enable && clock_strap_pins_i == 2'h1 |=> fn1_q == crso_pkg::FN_REF)
		else $error("strap code 1 did not give reference");
	AST_REG_DIV4: assert property (overrange_output_enable && mode1 == 2'h3 |=> fn1_q == crso_pkg::FN_DIV4)
		else $error("register mode 3 did not give divide by 4");
	AST_DIV_OVER_ORNG: assert property (!overrange_output_enable && orng_en && clock_strap_pins_i == 2'h2
		|=> fn1_q == crso_pkg::FN_DIV2)
		else $error("over-range beat divided clock");
	AST_SECOND_STRAP: assert property (!overrange_output_enable && clock_strap_pins_i == 2'h3 |=> fn2_q == crso_pkg::FN_REF)
		else $error("second output divided from straps");
	AST_SECOND_GATED: assert property (overrange_output_enable && mode1 == 2'h0
		|=> fn2_q == crso_pkg::FN_OFF || fn2_q == crso_pkg::FN_ORNG)
		else $error("second clock without first mode");
	AST_REF_SEL: assert property (ref_input_select_pin_i && single_ended_clock_input_i |=> ref_q)
		else $error("single-ended reference not selected");
	AST_REF_OUT: assert property (fn1_q == crso_pkg::FN_REF && !power_down_pin_i
		|=> aux_out_first_o == $past(ref_q))
		else $error("first output does not follow reference");
	AST_WB_ACK: assert property (s_req |=> s_ack_pulse)
		else $error("ack not a single cycle after request");
endmodule // crso_top
`default_nettype wire

// File: test/crso_ref_sink.sv
// Partner model: reference clock consumer counting rising edges on both aux outputs
`default_nettype none
module crso_ref_sink (
	input  wire logic       clk_i,        // Consumer samples on the system clock
	input  wire logic       clr_i,        // Clears both edge counters
	input  wire logic       first_i,      // Main consumer sits on the first output
	input  wire logic       second_i,     // Optional second consumer
	output logic      [7:0] first_cnt_o,  // Rises seen on the first output
	output logic      [7:0] second_cnt_o  // Rises seen on the second output
);
	timeunit 1ns;
	timeprecision 1ps;
	logic first_q;   // Previous first level
	logic second_q;  // Previous second level
	// Outputs are slow levels, so sampling on clk sees every edge
	always @(posedge clk_i) begin
		first_q <= first_i;
		second_q <= second_i;
		first_cnt_o <= clr_i ? 8'h00 : first_cnt_o + 8'(first_i & ~first_q);
		second_cnt_o <= clr_i ? 8'h00 : second_cnt_o + 8'(second_i & ~second_q);
	end
endmodule // crso_ref_sink
`default_nettype wire

// File: test/tb.sv
// Testbench: decode, override and power-down checks of the aux outputs
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'h0;
	logic        rst_i = 1'h1;
	logic        cyc = 1'h0, stb = 1'h0, we = 1'h0, clr = 1'h0;
	logic [3:0]  adr = 4'h0, sel4 = 4'h0;
	logic [31:0] wdat = 32'h0, rdat;
	logic        ack, aux1, aux2;
	logic [1:0]  strap = 2'h1;
	logic        pd = 1'h0, rsel = 1'h0, diff = 1'h0, se = 1'h0, or1 = 1'h0, or2 = 1'h0;
	logic [7:0]  cnt1, cnt2;
	logic [31:0] q[$];      // Expected read data, oldest first
	int          fail_count = 0;
	int          cmp_count = 0;

	crso_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel4), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .clock_strap_pins_i(strap), .power_down_pin_i(pd),
		.ref_input_select_pin_i(rsel), .diff_clock_input_i(diff),
		.single_ended_clock_input_i(se), .overrange_first_i(or1),
		.overrange_second_i(or2), .aux_out_first_o(aux1), .aux_out_second_o(aux2));
	crso_ref_sink sink_u (.clk_i(clk_i), .clr_i(clr), .first_i(aux1), .second_i(aux2),
		.first_cnt_o(cnt1), .second_cnt_o(cnt2));

	// 200 MHz clock
	initial forever #2.5 clk_i = ~clk_i;

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// Classic cycle: hold everything until ack is sampled, then release
	// Byte lanes default to the whole word; a narrower mask tests lane writes
	task automatic wb(input logic w_en, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w_en;
		adr <= a;
		wdat <= d;
		sel4 <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'h1 && n < 16);
		cyc <= 1'h0;
		stb <= 1'h0;
		if (n >= 16) begin
			fail_count++;
			print_verdict();
		end
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		q.push_back(e);
		wb(1'h0, a, 32'h0);
	endtask

	// Watcher: read data is valid in the ack cycle
	always @(posedge clk_i) begin
		if (ack === 1'h1 && we === 1'h0)
			check(rdat, (q.size() > 0) ? q.pop_front() : 32'hDEAD_BEEF);
	end

	function automatic logic [4:0] fn_of(input logic [1:0] m, input logic o);
		case (m)
			crso_pkg::MODE_REF:  return crso_pkg::FN_REF;
			crso_pkg::MODE_DIV2: return crso_pkg::FN_DIV2;
			crso_pkg::MODE_DIV4: return crso_pkg::FN_DIV4;
			default:             return o ? crso_pkg::FN_ORNG : crso_pkg::FN_OFF;
		endcase
	endfunction

	// Eight reference rises give 8, 4 or 2 output rises; off gives none
	function automatic logic [7:0] edges(input logic [1:0] m);
		return (m == 2'h0) ? 8'h00 : (8'h08 >> (m - 2'h1));
	endfunction

	// Selected input makes 8 slow rises; the other one toggles every cycle
	task automatic count(input logic [7:0] e1, input logic [7:0] e2);
		repeat (4) @(posedge clk_i);
		clr <= 1'h1;
		@(posedge clk_i);
		clr <= 1'h0;
		for (int i = 0; i < 64; i++) begin
			@(posedge clk_i);
			diff <= rsel ? i[0] : ~i[2];
			se <= rsel ? ~i[2] : i[0];
		end
		@(posedge clk_i);
		diff <= 1'h0;
		se <= 1'h0;
		repeat (6) @(posedge clk_i);
		check({24'h0, cnt1}, e1);
		check({24'h0, cnt2}, e2);
	endtask

	task automatic apply(input logic ov, input logic [1:0] m1, input logic [1:0] m2,
		input logic [1:0] s, input logic p);
		logic [31:0] w;
		logic [1:0]  c1;
		logic [1:0]  c2;
		w = $urandom;
		w[0] = ov;
		w[5:4] = m1;
		w[9:8] = m2;
		// Over-range on while the divide-by-2 strap is chosen, so the divider must win
		if (!ov && s == crso_pkg::MODE_DIV2)
			w[1] = 1'h1;
		c1 = ov ? m1 : s;
		c2 = (c1 == 2'h0) ? 2'h0 : (ov ? m2 : 2'h1);
		@(posedge clk_i);
		strap <= s;
		pd <= p;
		rsel <= w[12];
		or1 <= w[13];
		or2 <= w[14];
		wb(1'h1, crso_pkg::ADDR_CTRL, w);
		rd(crso_pkg::ADDR_CTRL, w);
		// Function codes are decoded even in power-down; the pin level shows too
		rd(crso_pkg::ADDR_STATUS, {10'h0, w[12], p, 2'h0, s, 3'h0, fn_of(c2, w[1]), 3'h0,
			fn_of(c1, w[1])});
		count(p ? 8'h00 : edges(c1), p ? 8'h00 : edges(c2));
	endtask

	// Main sequence
	initial begin
		void'($urandom(32'hBF5C5EDA));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		rd(crso_pkg::ADDR_CTRL, crso_pkg::CTRL_RESET);
		count(8'h08, 8'h08);
		for (int i = 0; i < 16; i++)
			apply(1'h0, i[3:2], ~i[3:2], i[1:0], 1'h0);
		for (int i = 0; i < 16; i++)
			apply(1'h1, i[1:0], i[3:2], ~i[1:0], 1'h0);
		apply(1'h0, 2'h0, 2'h0, 2'h1, 1'h1);
		apply(1'h1, 2'h3, 2'h3, 2'h0, 1'h1);
		// Byte lanes: only the selected lane of the control word may change
		wb(1'h1, crso_pkg::ADDR_CTRL, 32'h0000_0000);
		wb(1'h1, crso_pkg::ADDR_CTRL, 32'hFFFF_FFFF, 4'h2);
		rd(crso_pkg::ADDR_CTRL, 32'h0000_FF00);
		// Unmapped and status writes are acked but must leave control alone
		wb(1'h1, 4'h8, 32'hFFFF_FFFF);
		rd(4'h8, 32'h0);
		wb(1'h1, crso_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
		rd(crso_pkg::ADDR_CTRL, 32'h0000_FF00);
		repeat (4) @(posedge clk_i);
		print_verdict();
	end
endmodule // tb
`default_nettype wire
